// ### pkg/fcs_pkg.sv
// Constants and carrier types for the frequency command selector.
// How it works
// - No analog switch terminal assigned: command is voltage plus current input.
// - Pair select 00 with switch terminal: off voltage, on current input.
// - Pair select 02: switch off voltage input, switch on remote knob.
// - Pair select 03: switch off current input, switch on remote knob.
// - Full analog span maps linearly from zero to maximum frequency.
// - Preset speeds 1 to 15 override the frequency source selection.
// - Priority: forced terminal, then forced operation, then jog.
// - Preset mode 00 selects binary decoding, 01 selects one-hot bit decoding.
// - Binary mode: four terminals form index 0 to 15, fourth is MSB.
// - Bit mode: active one-hot terminal picks speed 1 to 7, none picks 0.
// - Function codes 02 to 05 map binary speed bits to any terminal.
// - Function codes 32 to 38 map one-hot speed bits to any terminal.
// - Setpoint write also stores the value into the selected preset entry.
// - All preset terminals off: speed 0 from the selected frequency source.
// - Preset speed zero is the command when source select is parameter (02).
// - Settling time 0 to 200 in 10 ms steps confirms binary-mode preset changes.
// - Binary mode latches new index only after settling since the last edge.
// - Bit mode with several terminals on picks the lowest numbered one.
package fcs_pkg;
   // Sizes
   localparam int NTERM = 7;
   localparam int FW    = 16;  // Frequency in 0.01 Hz
   localparam int AW    = 10;  // Converter width
   localparam int NPRE  = 16;
   localparam int IW    = 4;
   localparam int CW    = 7;   // Function code width
   localparam int SW    = 8;   // Settle setting width

   // Input function codes
   localparam logic [CW-1:0] FN_BIN0    = 7'h02;
   localparam logic [CW-1:0] FN_JOG     = 7'h06;
   localparam logic [CW-1:0] FN_SWITCH  = 7'h10;
   localparam logic [CW-1:0] FN_FORCEOP = 7'h1f;
   localparam logic [CW-1:0] FN_HOT0    = 7'h20;
   localparam logic [CW-1:0] FN_FORCETM = 7'h33;
   localparam int            NBIN       = 4;
   localparam int            NHOT       = 7;

   // Setting encodings
   localparam logic [1:0] PAIR_VC = 2'h0;
   localparam logic [1:0] PAIR_VK = 2'h2;
   localparam logic [1:0] PAIR_CK = 2'h3;
   localparam logic [1:0] SRC_KNOB  = 2'h0;
   localparam logic [1:0] SRC_TERM  = 2'h1;
   localparam logic [1:0] SRC_PARAM = 2'h2;
   localparam logic       MODE_BIN  = 1'b0;
   localparam logic       MODE_HOT  = 1'b1;

   // Analog full scale and settle timing
   localparam logic [AW-1:0] ANA_FULL = 10'h3ff;
   localparam int SETTLE_STEP_MS  = 10;
   localparam int CLK_HZ          = 20_000_000;
   localparam int SETTLE_STEP_CYC = CLK_HZ / 1000 * SETTLE_STEP_MS;
   localparam logic [SW-1:0] SETTLE_MAX = 8'hc8;

   // Reset values
   localparam logic [FW-1:0] FREQ_RST = 16'h0000;
   localparam logic [IW-1:0] IDX_RST  = 4'h0;

   typedef logic [NTERM-1:0][CW-1:0] fcs_fnmap_t;

   typedef struct packed {
      logic [1:0]    pair_sel;
      logic [1:0]    src_sel;
      logic          mode;
      logic [SW-1:0] settle;
      logic [FW-1:0] max_freq;
      logic [FW-1:0] jog_freq;
      logic [FW-1:0] force_op_freq;
   } fcs_cfg_t;

   typedef struct packed {
      logic [AW-1:0] volt;
      logic [AW-1:0] curr;
      logic [AW-1:0] knob;
   } fcs_ana_t;

   typedef enum logic [2:0] {
      SEL_SPEED0, SEL_PRESET, SEL_JOG, SEL_FORCEOP, SEL_FORCETM
   } fcs_sel_t;
endpackage

// ### src/fcs_preset_mem.sv
// Preset speed table with one write port and a registered read port.
`timescale 1ns/10ps
`default_nettype none
module fcs_preset_mem
   import fcs_pkg::*;
#(
   parameter int DEPTH = NPRE,
   parameter int WIDTH = FW
) (
   // Clock and reset
   input  wire logic                     clk_i,
   input  wire logic                     arst_n_i,
   // Write port
   input  wire logic                     wr_i,
   input  wire logic [$clog2(DEPTH)-1:0] waddr_i,
   input  wire logic [WIDTH-1:0]         wdata_i,
   // Read port
   input  wire logic [$clog2(DEPTH)-1:0] raddr_i,
   output logic      [WIDTH-1:0]         rdata_o
);
   logic [WIDTH-1:0] mem_q [DEPTH];

   // Storage; no reset so it maps to plain RAM
   always_ff @(posedge clk_i) begin
      if (wr_i) begin
         mem_q[waddr_i] <= wdata_i;
      end
   end

   // Read data from a register, write-through for same-cycle update
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rdata_o <= '0;
      end else if (wr_i && waddr_i == raddr_i) begin
         rdata_o <= wdata_i;
      end else begin
         rdata_o <= mem_q[raddr_i];
      end
   end
endmodule
`default_nettype wire

// ### src/fcs_top.sv
// Frequency command selector: analog pairing, preset decode, priority.
`timescale 1ns/10ps
`default_nettype none
module fcs_top
   import fcs_pkg::*;
#(
   parameter int STEP_CYC = SETTLE_STEP_CYC
) (
   // Clock and reset
   input  wire logic             CLK_I,
   input  wire logic             ARST_N_I,
   // Terminal pins and their function assignment
   input  wire logic [NTERM-1:0] TERM_I,
   input  wire fcs_fnmap_t       FUNC_ASSIGN_I,
   // Settings
   input  wire fcs_cfg_t         CFG_I,
   // Digitised analog inputs
   input  wire fcs_ana_t         ANA_I,
   // Setpoint monitor write
   input  wire logic             SETPT_WR_I,
   input  wire logic [FW-1:0]    SETPT_DATA_I,
   // Direct preset table write
   input  wire logic             PRESET_WR_I,
   input  wire logic [IW-1:0]    PRESET_ADDR_I,
   input  wire logic [FW-1:0]    PRESET_DATA_I,
   // Results
   output logic      [FW-1:0]    FREQ_CMD_O,
   output logic      [IW-1:0]    PRESET_IDX_O,
   output var fcs_sel_t          CMD_SEL_O,
   output logic                  SETTLING_O
);
   localparam int TCW = $clog2(STEP_CYC + 1);

   logic [NTERM-1:0] s1_q, s2_q, s3_q, term_q;
   logic [NBIN-1:0]  bin_bits;
   logic [NHOT-1:0]  hot_bits;
   logic             sw_on, sw_assigned, jog_on, fop_on, ftm_on;
   logic [IW-1:0]    bin_idx, hot_idx, live_idx;
   logic [IW-1:0]    idx_q;
   logic [NBIN-1:0]  bin_prev_q;
   logic             bin_edge;
   logic             settle_req;
   logic [SW-1:0]    settle_lim;
   logic [TCW-1:0]   div_q;
   logic [SW-1:0]    steps_q;
   logic             tick;
   logic [FW-1:0]    volt_f, curr_f, knob_f, term_f, src_f, pre_f;
   logic [FW:0]      sum_f;
   logic             mem_wr;
   logic [IW-1:0]    mem_waddr;
   logic [FW-1:0]    mem_wdata;
   fcs_sel_t         sel;

   typedef enum logic {ST_STABLE, ST_SETTLE} fcs_st_t;
   fcs_st_t st_q;

   // Three-stage pin synchroniser; a change counts once stages two and three agree
   // Stage one may be metastable, so nothing but stage two reads it
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         s1_q   <= '0;
         s2_q   <= '0;
         s3_q   <= '0;
         term_q <= '0;
      end else begin
         s1_q <= TERM_I;
         s2_q <= s1_q;
         s3_q <= s2_q;
         for (int t = 0; t < NTERM; t++) begin
            if (s2_q[t] == s3_q[t]) begin
               term_q[t] <= s3_q[t];
            end
         end
      end
   end

   // Preset speed functions; unassigned functions stay off
   always_comb begin
      bin_bits = '0;
      hot_bits = '0;
      for (int t = 0; t < NTERM; t++) begin
         for (int b = 0; b < NBIN; b++) begin
            if (FUNC_ASSIGN_I[t] == FN_BIN0 + CW'(b)) begin
               bin_bits[b] = bin_bits[b] | term_q[t];
            end
         end
         for (int h = 0; h < NHOT; h++) begin
            if (FUNC_ASSIGN_I[t] == FN_HOT0 + CW'(h)) begin
               hot_bits[h] = hot_bits[h] | term_q[t];
            end
         end
      end
   end

   // Switch and forcing functions; several terminals with one function are ORed
   always_comb begin
      sw_on       = 1'b0;
      sw_assigned = 1'b0;
      jog_on      = 1'b0;
      fop_on      = 1'b0;
      ftm_on      = 1'b0;
      for (int t = 0; t < NTERM; t++) begin
         if (FUNC_ASSIGN_I[t] == FN_SWITCH) begin
            sw_assigned = 1'b1;
            sw_on       = sw_on | term_q[t];
         end
         if (FUNC_ASSIGN_I[t] == FN_JOG) begin
            jog_on = jog_on | term_q[t];
         end
         if (FUNC_ASSIGN_I[t] == FN_FORCEOP) begin
            fop_on = fop_on | term_q[t];
         end
         if (FUNC_ASSIGN_I[t] == FN_FORCETM) begin
            ftm_on = ftm_on | term_q[t];
         end
      end
   end

   // Binary index, fourth bit most significant
   assign bin_idx = bin_bits;

   // One-hot index; scanning downward leaves the lowest active bit
   always_comb begin
      hot_idx = '0;
      for (int h = NHOT - 1; h >= 0; h--) begin
         if (hot_bits[h]) begin
            hot_idx = IW'(h + 1);
         end
      end
   end

   assign live_idx = (CFG_I.mode == MODE_HOT) ? hot_idx : bin_idx;
   assign bin_edge = (bin_bits != bin_prev_q);

   // An edge opens a wait only when a settle time is set
   assign settle_req = bin_edge && (CFG_I.settle != '0);

   // Settings past the top of the range run the longest wait
   assign settle_lim = (CFG_I.settle > SETTLE_MAX) ? SETTLE_MAX : CFG_I.settle;

   // Edge memory for the binary speed bits
   // Resets to the idle level so a release gives no false edge
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         bin_prev_q <= '0;
      end else begin
         bin_prev_q <= bin_bits;
      end
   end

   // Step divider: one tick per settle step, restarted by any edge
   // Held at zero while stable so the first step is a full one
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         div_q <= '0;
      end else if (bin_edge || st_q == ST_STABLE || tick) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + TCW'(1);
      end
   end
   assign tick = (st_q == ST_SETTLE) && (div_q == TCW'(STEP_CYC - 1));

   // Settle sequencer; a new edge restarts the whole wait
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         st_q    <= ST_STABLE;
         steps_q <= '0;
      end else if (CFG_I.mode == MODE_HOT) begin
         // Bit mode never waits
         st_q    <= ST_STABLE;
         steps_q <= '0;
      end else if (settle_req) begin
         st_q    <= ST_SETTLE;
         steps_q <= settle_lim;
      end else begin
         unique case (st_q)
            ST_STABLE: st_q <= ST_STABLE;
            ST_SETTLE: begin
               if (tick) begin
                  steps_q <= steps_q - SW'(1);
                  if (steps_q == SW'(1)) begin
                     st_q <= ST_STABLE;
                  end
               end
            end
         endcase
      end
   end

   // Confirmed preset index; binary mode waits for the settle sequencer
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         idx_q <= IDX_RST;
      end else if (CFG_I.mode == MODE_HOT) begin
         // Bit mode follows the terminals at once
         idx_q <= live_idx;
      end else if (st_q == ST_STABLE && !settle_req) begin
         idx_q <= live_idx;
      end
   end

   // Setpoint writes land in the selected preset; direct writes otherwise
   // A direct write in the same cycle as a setpoint write is dropped
   assign mem_wr    = SETPT_WR_I | PRESET_WR_I;
   assign mem_waddr = SETPT_WR_I ? idx_q : PRESET_ADDR_I;
   assign mem_wdata = SETPT_WR_I ? SETPT_DATA_I : PRESET_DATA_I;

   fcs_preset_mem #(
      .DEPTH (NPRE),
      .WIDTH (FW)
   ) u_mem (
      .clk_i    (CLK_I),
      .arst_n_i (ARST_N_I),
      .wr_i     (mem_wr),
      .waddr_i  (mem_waddr),
      .wdata_i  (mem_wdata),
      .raddr_i  (idx_q),
      .rdata_o  (pre_f)
   );

   // Linear scaling of one converter value onto zero..maximum
   // Truncating divide; the full code lands exactly on the maximum
   function automatic logic [FW-1:0] scale(input logic [AW-1:0] a,
                                           input logic [FW-1:0] fmax);
      logic [FW+AW-1:0] p;
      p = (FW + AW)'(a) * (FW + AW)'(fmax);
      return FW'(p / (FW + AW)'(ANA_FULL));
   endfunction

   assign volt_f = scale(ANA_I.volt, CFG_I.max_freq);
   assign curr_f = scale(ANA_I.curr, CFG_I.max_freq);
   assign knob_f = scale(ANA_I.knob, CFG_I.max_freq);
   assign sum_f  = {1'b0, volt_f} + {1'b0, curr_f};

   // Terminal command: sum when unswitched, otherwise the chosen pair
   always_comb begin
      if (!sw_assigned) begin
         // Clamp so the sum never exceeds maximum frequency
         term_f = (sum_f > {1'b0, CFG_I.max_freq}) ? CFG_I.max_freq
                                                    : sum_f[FW-1:0];
      end else begin
         unique case (CFG_I.pair_sel)
            PAIR_VK: term_f = sw_on ? knob_f : volt_f;
            PAIR_CK: term_f = sw_on ? knob_f : curr_f;
            default: term_f = sw_on ? curr_f : volt_f;
         endcase
      end
   end

   // Speed-zero source
   // Code 03 has no source of its own and falls back to the knob
   always_comb begin
      unique case (CFG_I.src_sel)
         SRC_TERM:  src_f = term_f;
         SRC_PARAM: src_f = pre_f;
         default:   src_f = knob_f;
      endcase
   end

   // Priority among forcing functions, then presets, then the source
   always_comb begin
      if (ftm_on) begin
         sel = SEL_FORCETM;
      end else if (fop_on) begin
         sel = SEL_FORCEOP;
      end else if (jog_on) begin
         sel = SEL_JOG;
      end else if (idx_q != '0) begin
         sel = SEL_PRESET;
      end else begin
         sel = SEL_SPEED0;
      end
   end

   // Source, index and settle flag registers
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         CMD_SEL_O    <= SEL_SPEED0;
         PRESET_IDX_O <= IDX_RST;
         SETTLING_O   <= 1'b0;
      end else begin
         CMD_SEL_O    <= sel;
         PRESET_IDX_O <= idx_q;
         SETTLING_O   <= (st_q == ST_SETTLE);
      end
   end

   // Frequency register; keeps glitches of the source mux off the output
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         FREQ_CMD_O <= FREQ_RST;
      end else begin
         unique case (sel)
            SEL_FORCETM: FREQ_CMD_O <= term_f;
            SEL_FORCEOP: FREQ_CMD_O <= CFG_I.force_op_freq;
            SEL_JOG:     FREQ_CMD_O <= CFG_I.jog_freq;
            SEL_PRESET:  FREQ_CMD_O <= pre_f;
            SEL_SPEED0:  FREQ_CMD_O <= src_f;
         endcase
      end
   end
endmodule
`default_nettype wire

// ### test/fcs_checker.sv
// Port-level assertions for the frequency command selector.
`timescale 1ns/10ps
`default_nettype none
module fcs_checker
   import fcs_pkg::*;
#(
   parameter int STEP_CYC = SETTLE_STEP_CYC
) (
   // Clock and reset
   input wire logic          CLK_I,
   input wire logic          ARST_N_I,
   // Settings and results
   input wire fcs_cfg_t      CFG_I,
   input wire logic [FW-1:0] FREQ_CMD_O,
   input wire logic [IW-1:0] PRESET_IDX_O,
   input wire fcs_sel_t      CMD_SEL_O,
   input wire logic          SETTLING_O
);
   int unsigned run_q;
   int unsigned lim;
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!ARST_N_I);
   // Length of the current settle wait, settings above the top clamp
   assign lim = (CFG_I.settle > SETTLE_MAX ? 200 : CFG_I.settle) * STEP_CYC;
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) run_q <= 0;
      else run_q <= SETTLING_O ? run_q + 1 : 0;
   end
   sequence hot_steady;
      (CFG_I.mode == MODE_HOT) [*8];
   endsequence
   sequence settle_hold;
      SETTLING_O [*2];
   endsequence
   forceop_val_a:
   assert property ($stable(CFG_I) && CMD_SEL_O == SEL_FORCEOP |->
                    FREQ_CMD_O == CFG_I.force_op_freq)
      else $error("forced operation value wrong");
   jog_val_a:
   assert property ($stable(CFG_I) && CMD_SEL_O == SEL_JOG |-> FREQ_CMD_O == CFG_I.jog_freq)
      else $error("jog value wrong");
   forcetm_cap_a:
   assert property ($stable(CFG_I) && CMD_SEL_O == SEL_FORCETM |-> FREQ_CMD_O <= CFG_I.max_freq)
      else $error("analog command above maximum");
   hot_range_a:
   assert property (hot_steady |-> PRESET_IDX_O <= 4'h7) else $error("bit mode index above 7");
   hot_nosettle_a:
   assert property (hot_steady |-> !SETTLING_O) else $error("settle wait in bit mode");
   idx_frozen_a:
   assert property (settle_hold |-> $stable(PRESET_IDX_O)) else $error("index moved while settling");
   settle_len_a:
   assert property ($fell(SETTLING_O) |-> run_q >= lim) else $error("settle wait too short");
   preset_idx_a:
   assert property ((CMD_SEL_O == SEL_PRESET) [*3] |-> PRESET_IDX_O != 4'h0)
      else $error("preset source with index zero");
endmodule
bind fcs_top fcs_checker #(.STEP_CYC(STEP_CYC)) u_chk (.CLK_I(CLK_I), .ARST_N_I(ARST_N_I),
   .CFG_I(CFG_I), .FREQ_CMD_O(FREQ_CMD_O), .PRESET_IDX_O(PRESET_IDX_O),
   .CMD_SEL_O(CMD_SEL_O), .SETTLING_O(SETTLING_O));
`default_nettype wire

// ### test/fcs_term_model.sv
// Terminal block model: pin levels and converter codes toward the selector.
`timescale 1ns/10ps
`default_nettype none
module fcs_term_model
   import fcs_pkg::*;
(
   // Requested levels
   input  wire logic [NTERM-1:0] pins_i,
   input  wire fcs_ana_t         ana_i,
   // Toward the selector
   output logic      [NTERM-1:0] term_o,
   output var fcs_ana_t          ana_o
);
   // Contacts settle instantly; bounce is left to the settle scenario
   always_comb begin
      term_o = pins_i;
      ana_o  = ana_i;
   end
endmodule
`default_nettype wire

// ### test/testbench.sv
// Self-checking bench for the frequency command selector.
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import fcs_pkg::*;
   logic             clk = 1'b0;
   logic             arst_n = 1'b0;
   logic [NTERM-1:0] pins = '0;
   fcs_fnmap_t       fmap = '0;
   fcs_cfg_t         cfg = '0;
   fcs_ana_t         areq = '0;
   logic             sp_wr = 1'b0;
   logic             pr_wr = 1'b0;
   logic [IW-1:0]    pr_addr = '0;
   logic [FW-1:0]    wdat = '0;
   logic [NTERM-1:0] term;
   fcs_ana_t         ana;
   logic [FW-1:0]    freq;
   logic [IW-1:0]    idx;
   fcs_sel_t         sel;
   logic             settling;
   int               fails = 0;
   int               tests_run = 0;
   logic [1:0]       prs [3] = '{PAIR_VC, PAIR_VK, PAIR_CK};
   logic [AW-1:0]    offs [3] = '{10'h200, 10'h200, 10'h100};
   logic [AW-1:0]    ons [3] = '{10'h100, 10'h3ff, 10'h3ff};
   // Free-running 20 MHz clock
   always #25 clk = ~clk;
   fcs_term_model u_term (.pins_i(pins), .ana_i(areq), .term_o(term), .ana_o(ana));
   fcs_top #(.STEP_CYC(4)) dut (.CLK_I(clk), .ARST_N_I(arst_n), .TERM_I(term),
      .FUNC_ASSIGN_I(fmap), .CFG_I(cfg), .ANA_I(ana), .SETPT_WR_I(sp_wr), .SETPT_DATA_I(wdat),
      .PRESET_WR_I(pr_wr), .PRESET_ADDR_I(pr_addr), .PRESET_DATA_I(wdat), .FREQ_CMD_O(freq),
      .PRESET_IDX_O(idx), .CMD_SEL_O(sel), .SETTLING_O(settling));
   task automatic w(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic chk(input logic [FW-1:0] got, input logic [FW-1:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Pins pass a 3-stage sync, so allow the full path before looking
   task automatic apply(input logic [NTERM-1:0] p, input logic [FW-1:0] f,
                        input logic [IW-1:0] i, input fcs_sel_t s);
      pins = p;
      w(8);
      chk(freq, f);
      chk({12'h000, idx}, {12'h000, i});
      chk({13'h0000, sel}, {13'h0000, s});
   endtask
   function automatic logic [FW-1:0] scl(input logic [AW-1:0] a);
      return FW'((32'(a) * 32'(cfg.max_freq)) / 1023);
   endfunction
   function automatic logic [NTERM-1:0] bpins(input logic [3:0] i);
      return {i[0], 1'b0, i[1], 1'b0, i[2], 1'b0, i[3]};
   endfunction
   task automatic wrap_up();
      $display("Checks %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // Watchdog well beyond the few hundred cycles the tests need
   initial begin
      #(50 * 6000);
      fails++;
      wrap_up();
   end
   initial begin
      cfg.max_freq = 16'h1000;
      cfg.jog_freq = 16'h0123;
      cfg.force_op_freq = 16'h0456;
      cfg.src_sel = SRC_PARAM;
      areq = '{volt: 10'h200, curr: 10'h100, knob: ANA_FULL};
      w(4);
      arst_n = 1'b1;
      // Table has no reset: entry n holds 0x0100 plus n
      pr_wr = 1'b1;
      for (int n = 0; n < NPRE; n++) begin
         pr_addr = n[IW-1:0];
         wdat = 16'h0100 + 16'(n);
         w(1);
      end
      pr_wr = 1'b0;
      // Binary bits scattered over terminals 6, 4, 2, 0
      for (int b = 0; b < NBIN; b++) fmap[6 - 2 * b] = FN_BIN0 + 7'(b);
      for (int i = 0; i < NPRE; i++)
         apply(bpins(i[3:0]), 16'h0100 + 16'(i), i[3:0],
               i == 0 ? SEL_SPEED0 : SEL_PRESET);
      fmap[0] = 7'h00;
      apply(bpins(4'hf), 16'h0107, 4'h7, SEL_PRESET);
      $display("Binary preset test done");
      cfg.mode = MODE_HOT;
      for (int k = 0; k < NHOT; k++) fmap[k] = FN_HOT0 + 7'(k);
      for (int k = 0; k < NHOT; k++)
         apply(7'h7f << k, 16'h0101 + 16'(k), IW'(k + 1), SEL_PRESET);
      apply(7'h00, 16'h0100, 4'h0, SEL_SPEED0);
      apply(7'h04, 16'h0103, 4'h3, SEL_PRESET);
      wdat = 16'h0abc;
      sp_wr = 1'b1;
      w(1);
      sp_wr = 1'b0;
      w(3);
      chk(freq, 16'h0abc);
      apply(7'h00, 16'h0100, 4'h0, SEL_SPEED0);
      apply(7'h04, 16'h0abc, 4'h3, SEL_PRESET);
      $display("Bit preset and setpoint test done");
      cfg.src_sel = SRC_TERM;
      apply(7'h00, scl(10'h200) + scl(10'h100), 4'h0, SEL_SPEED0);
      fmap[6] = FN_SWITCH;
      for (int p = 0; p < 3; p++) begin
         cfg.pair_sel = prs[p];
         apply(7'h00, scl(offs[p]), 4'h0, SEL_SPEED0);
         apply(7'h40, scl(ons[p]), 4'h0, SEL_SPEED0);
      end
      chk(freq, cfg.max_freq);
      cfg.src_sel = SRC_KNOB;
      apply(7'h00, scl(ANA_FULL), 4'h0, SEL_SPEED0);
      $display("Analog source test done");
      fmap[3] = FN_JOG;
      fmap[4] = FN_FORCEOP;
      fmap[5] = FN_FORCETM;
      fmap[6] = 7'h00;
      apply(7'h39, scl(10'h200) + scl(10'h100), 4'h1, SEL_FORCETM);
      apply(7'h19, 16'h0456, 4'h1, SEL_FORCEOP);
      apply(7'h09, 16'h0123, 4'h1, SEL_JOG);
      apply(7'h01, 16'h0101, 4'h1, SEL_PRESET);
      $display("Priority test done");
      cfg = '{mode: MODE_BIN, settle: 8'h02, src_sel: SRC_PARAM, max_freq: 16'h1000, default: '0};
      for (int b = 0; b < NTERM; b++) fmap[b] = b < NBIN ? FN_BIN0 + 7'(b) : 7'h00;
      pins = 7'h00;
      w(20);
      pins = 7'h05;
      w(6);
      chk({15'h0000, settling}, 16'h0001);
      chk({12'h000, idx}, 16'h0000);
      pins = 7'h06;
      // Past the end of an unrestarted wait, still inside the restarted one
      w(10);
      chk({12'h000, idx}, 16'h0000);
      w(10);
      chk({12'h000, idx}, 16'h0006);
      chk(freq, 16'h0106);
      chk({15'h0000, settling}, 16'h0000);
      $display("Settle test done");
      arst_n = 1'b0;
      w(2);
      chk(freq, FREQ_RST);
      chk({12'h000, idx}, {12'h000, IDX_RST});
      arst_n = 1'b1;
      // Table keeps its contents; speed 0 comes back from entry 0
      w(4);
      chk(freq, 16'h0100);
      w(14);
      chk({12'h000, idx}, 16'h0006);
      chk(freq, 16'h0106);
      $display("Reset test done");
      wrap_up();
   end
endmodule
`default_nettype wire
